//--- logic/discrete_io_fail_safe.sv
// Discrete input/output block with fail-safe output control
//
// Functional notes
// R1: Inputs read active while sensing current flows; inputs are read-only.
// R2: Twenty-four inputs: bytes 0-2, halfwords 0-1, one 32-bit word.
// R3: Thirty-two inputs: bytes 0-3, halfwords 0-1, one 32-bit word.
// R4: Four outputs readable and writable singly or as grouped low bits.
// R5: Four-point module keeps low nibble of written values; rest dropped.
// R6: Fail-safe type 1 all off, 2 pattern, 3 hold last state.
// R7: Stored pattern drives outputs only when type equals 2.
// R8: Pattern bit one drives point on, zero drives point off.
// R9: Loss of host communication puts outputs in configured fail-safe.
// R10: Fail-safe entry delayed by programmed tenths of a second.
// R11: Delay is an 8-bit count, up to 25.5 seconds.
// R12: Zero delay enters fail-safe immediately on communication loss.
// R13: Staged type, pattern and delay take effect only on commit.
// R14: Commit strobe clears itself after transfer; writing zero does nothing.
// R15: Reads wider than the module return zeros above its points.
// R16: Communication restored before delay expiry cancels fail-safe entry.
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
module discrete_io_fail_safe
  import dio_pkg::*;
#(
  parameter int          N_INPUTS  = 32,
  parameter int          N_OUTPUTS = 4,
  parameter int unsigned TICK_LEN  = 32'(TICK_CYCLES)
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 resetn_i,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]    avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [3:0]           avs_byteenable_i,
  input  wire logic [31:0]          avs_writedata_i,
  output logic [31:0]               avs_readdata_o,
  output logic                      avs_waitrequest_o,
  output logic [1:0]                avs_response_o,
  // Field pins
  input  wire logic [N_INPUTS-1:0]  input_point_i,
  input  wire logic                 host_link_ok_i,
  output logic [N_OUTPUTS-1:0]      output_point_o,
  // Interrupt
  output logic                      irq_o
);
  logic [N_OUTPUTS-1:0] normal_out_ff;
  logic [N_OUTPUTS-1:0] safe_output_pattern_ff;
  logic [N_OUTPUTS-1:0] staged_pattern_ff;
  logic [1:0]           safe_state_select_ff;
  logic [1:0]           staged_select_ff;
  logic [DELAY_W-1:0]   safe_entry_delay_ff;
  logic [DELAY_W-1:0]   staged_delay_ff;
  logic                 safe_config_commit_ff;
  logic [DELAY_W-1:0]   remain_ff;
  logic                 link_ff;
  logic [IRQ_BITS-1:0]  irq_status_ff;
  logic [IRQ_BITS-1:0]  irq_enable_ff;
  logic                 ack_ff;
  logic [31:0]          input_view;
  logic [31:0]          sense_wide;
  logic                 tick;
  logic                 wr_req;
  logic                 rd_req;
  logic [3:0]           word_idx;
  logic [31:0]          wmask;
  logic [31:0]          wdata;
  logic [31:0]          nxt_readdata;
  logic                 nxt_decerr;
  logic [N_OUTPUTS-1:0] nxt_out;
  logic [IRQ_BITS-1:0]  events;
  logic                 link_lost;
  logic                 link_back;
  safe_state_type       state_ff;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic is_mapped(input logic [3:0] idx);
    is_mapped = (idx <= REG_IRQ_CLEAR);
  endfunction

  assign sense_wide = 32'(input_point_i);
  assign word_idx   = avs_address_i[ADDR_LSB +: 4];
  assign wmask      = lane_mask(avs_byteenable_i);
  assign wdata      = avs_writedata_i & wmask;
  assign wr_req     = avs_write_i && !ack_ff;
  assign rd_req     = avs_read_i && !ack_ff;
  assign link_lost  = link_ff && !host_link_ok_i;
  assign link_back  = !link_ff && host_link_ok_i;

  // Point level already means current is flowing
  input_group_read #(
    .N_POINTS (N_INPUTS)
  ) u_inputs (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .sense_i   (sense_wide),    // see R1
    .points_o  (input_view)     // see R15
  );

  tick_divider #(
    .TICK_LEN (TICK_LEN)
  ) u_tick (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .restart_i (link_lost),
    .tick_o    (tick)
  );

  // One wait state: answer on the cycle after the request is seen
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read_i || avs_write_i) && !ack_ff;
    end
  end

  // Registered so the handshake output comes straight from a flop
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_ff);
    end
  end

  // Host-written output values, low bits only
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      normal_out_ff <= '0;
    end else if (wr_req && word_idx == REG_OUTPUT_POINT) begin
      normal_out_ff <= (normal_out_ff & ~wmask[N_OUTPUTS-1:0])
                       | wdata[N_OUTPUTS-1:0];  // see R4 see R5
    end
  end

  // Staging registers, inert until commit
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      staged_select_ff  <= SAFE_SELECT_RESET;
      staged_pattern_ff <= '0;
      staged_delay_ff   <= '0;
    end else if (wr_req) begin
      if (word_idx == REG_SAFE_SELECT && avs_byteenable_i[0]) begin
        staged_select_ff <= wdata[1:0];
      end
      if (word_idx == REG_SAFE_PATTERN) begin
        staged_pattern_ff <= (staged_pattern_ff & ~wmask[N_OUTPUTS-1:0])
                             | wdata[N_OUTPUTS-1:0];  // see R5
      end
      if (word_idx == REG_SAFE_DELAY && avs_byteenable_i[0]) begin
        staged_delay_ff <= wdata[DELAY_W-1:0];  // see R11
      end
    end
  end

  // Commit strobe: set by writing one, self-clears next cycle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      safe_config_commit_ff <= 1'b0;
    end else begin
      safe_config_commit_ff <= wr_req && word_idx == REG_SAFE_COMMIT
                               && wdata[COMMIT_BIT];  // see R14
    end
  end

  // Active fail-safe configuration
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      safe_state_select_ff   <= SAFE_SELECT_RESET;
      safe_output_pattern_ff <= '0;
      safe_entry_delay_ff    <= '0;
    end else if (safe_config_commit_ff) begin  // see R13
      safe_state_select_ff   <= staged_select_ff;
      safe_output_pattern_ff <= staged_pattern_ff;
      safe_entry_delay_ff    <= staged_delay_ff;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_ff <= 1'b1;
    end else begin
      link_ff <= host_link_ok_i;
    end
  end

  // Fail-safe sequencer
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff  <= ST_RUN;
      remain_ff <= '0;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (link_lost) begin  // see R9
            remain_ff <= safe_entry_delay_ff;  // see R10
            if (safe_entry_delay_ff == '0) begin
              state_ff <= ST_SAFE;  // see R12
            end else begin
              state_ff <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (host_link_ok_i) begin
            state_ff <= ST_RUN;  // see R16
          end else if (tick) begin
            remain_ff <= remain_ff - 1'b1;
            if (remain_ff == 8'h01) begin
              state_ff <= ST_SAFE;  // see R10
            end
          end
        end
        ST_SAFE: begin
          if (host_link_ok_i) begin
            state_ff <= ST_RUN;
          end
        end
        default: begin
          state_ff <= ST_RUN;
        end
      endcase
    end
  end

  // Output selection per fail-safe type
  always_comb begin
    nxt_out = normal_out_ff;
    if (state_ff == ST_SAFE) begin
      case (safe_state_select_ff)  // see R6
        SAFE_ALL_OFF:   nxt_out = '0;
        SAFE_PATTERN:   nxt_out = safe_output_pattern_ff;  // see R7 see R8
        SAFE_HOLD_LAST: nxt_out = normal_out_ff;
        default:        nxt_out = normal_out_ff;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      output_point_o <= '0;
    end else begin
      output_point_o <= nxt_out;
    end
  end

  // Sticky event flags; new events win over clears
  always_comb begin
    events                = '0;
    events[EV_LINK_LOST]  = link_lost;
    events[EV_SAFE_ENTER] = state_ff != ST_SAFE
                            && ((state_ff == ST_RUN && link_lost
                                 && safe_entry_delay_ff == '0)
                                || (state_ff == ST_WAIT && !host_link_ok_i
                                    && tick && remain_ff == 8'h01));
    events[EV_LINK_BACK]  = link_back;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status_ff <= '0;
    end else if (wr_req && word_idx == REG_IRQ_CLEAR) begin
      irq_status_ff <= (irq_status_ff & ~wdata[IRQ_BITS-1:0]) | events;
    end else begin
      irq_status_ff <= irq_status_ff | events;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_enable_ff <= '0;
    end else if (wr_req && word_idx == REG_IRQ_ENABLE) begin
      irq_enable_ff <= (irq_enable_ff & ~wmask[IRQ_BITS-1:0])
                       | wdata[IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((irq_status_ff | events) & irq_enable_ff);
    end
  end

  // Read mux; write-only registers read zero
  always_comb begin
    nxt_readdata = 32'h0000_0000;
    nxt_decerr   = !is_mapped(word_idx);
    case (word_idx)
      REG_INPUT_POINT:  nxt_readdata = input_view;  // see R2 see R3 see R15
      REG_OUTPUT_POINT: nxt_readdata = 32'(normal_out_ff);  // see R4
      REG_STATUS: begin
        nxt_readdata[STAT_LINK_BIT] = link_ff;
        nxt_readdata[STAT_SAFE_BIT] = state_ff == ST_SAFE;
        nxt_readdata[STAT_PEND_BIT] = state_ff == ST_WAIT;
      end
      REG_IRQ_STATUS:   nxt_readdata = 32'(irq_status_ff);
      REG_IRQ_ENABLE:   nxt_readdata = 32'(irq_enable_ff);
      default:          nxt_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
    end else if (rd_req || wr_req) begin
      avs_readdata_o <= rd_req ? nxt_readdata : 32'h0000_0000;
      avs_response_o <= nxt_decerr ? 2'h3 : 2'h0;
    end
  end
endmodule

//--- pkg/dio_pkg.sv
// Register map, field layout and timing constants of the discrete I/O block
package dio_pkg;
  // Register word offsets (byte address divided by four)
  localparam logic [3:0] REG_INPUT_POINT    = 4'h0;
  localparam logic [3:0] REG_OUTPUT_POINT   = 4'h1;
  localparam logic [3:0] REG_SAFE_SELECT    = 4'h2;
  localparam logic [3:0] REG_SAFE_PATTERN   = 4'h3;
  localparam logic [3:0] REG_SAFE_DELAY     = 4'h4;
  localparam logic [3:0] REG_SAFE_COMMIT    = 4'h5;
  localparam logic [3:0] REG_STATUS         = 4'h6;
  localparam logic [3:0] REG_IRQ_STATUS     = 4'h7;
  localparam logic [3:0] REG_IRQ_ENABLE     = 4'h8;
  localparam logic [3:0] REG_IRQ_CLEAR      = 4'h9;
  localparam int         ADDR_LSB           = 2;
  localparam int         ADDR_W             = 6;

  // Fail-safe type codes
  localparam logic [1:0] SAFE_ALL_OFF       = 2'h1;
  localparam logic [1:0] SAFE_PATTERN       = 2'h2;
  localparam logic [1:0] SAFE_HOLD_LAST     = 2'h3;
  localparam logic [1:0] SAFE_SELECT_RESET  = 2'h1;

  // Field positions
  localparam int         COMMIT_BIT         = 0;
  localparam int         STAT_LINK_BIT      = 0;
  localparam int         STAT_SAFE_BIT      = 1;
  localparam int         STAT_PEND_BIT      = 2;
  localparam int         IRQ_BITS           = 3;
  localparam int         EV_LINK_LOST       = 0;
  localparam int         EV_SAFE_ENTER      = 1;
  localparam int         EV_LINK_BACK       = 2;

  // Timing: one delay unit is a tenth of a second
  localparam longint     CLK_HZ             = 250_000_000;
  localparam longint     TICK_MS            = 100;
  localparam longint     TICK_CYCLES        = (CLK_HZ * TICK_MS) / 1000;
  localparam int         DELAY_W            = 8;

  typedef enum {
    ST_RUN,
    ST_WAIT,
    ST_SAFE
  } safe_state_type;
endpackage

//--- logic/tick_divider.sv
// Tenth-of-a-second enable pulse generator
`timescale 1ns/1ns
module tick_divider
  import dio_pkg::*;
#(
  parameter int unsigned TICK_LEN = 32'(TICK_CYCLES)
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  // Control
  input  wire logic restart_i,
  output logic      tick_o
);
  logic [31:0] count_ff;

  // Restart aligns the first tick to a full period
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_ff <= 32'h0000_0000;
      tick_o   <= 1'b0;
    end else if (restart_i || count_ff == TICK_LEN - 1) begin
      count_ff <= 32'h0000_0000;
      tick_o   <= !restart_i;
    end else begin
      count_ff <= count_ff + 32'h0000_0001;
      tick_o   <= 1'b0;
    end
  end
endmodule

//--- logic/input_group_read.sv
// Width-limited view of the input points, zero above the module width
`timescale 1ns/1ns
module input_group_read #(
  parameter int N_POINTS = 32
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // Field side
  input  wire logic [31:0] sense_i,
  // Register side
  output logic [31:0]      points_o
);
  logic [31:0] mask;

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_mask
      assign mask[g] = (g < N_POINTS);
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      points_o <= 32'h0000_0000;
    end else begin
      points_o <= sense_i & mask;
    end
  end
endmodule

//--- bench/io_props.sv
// Port-level checks of the discrete I/O block
`timescale 1ns/1ns
module io_props
  import dio_pkg::*;
#(
  parameter int N_INPUTS  = 32,
  parameter int N_OUTPUTS = 4
) (
  // Clock and reset
  input wire logic                 sys_clk_i,
  input wire logic                 resetn_i,
  // Register bus
  input wire logic [ADDR_W-1:0]    avs_address_i,
  input wire logic                 avs_read_i,
  input wire logic                 avs_write_i,
  input wire logic [3:0]           avs_byteenable_i,
  input wire logic [31:0]          avs_writedata_i,
  input wire logic [31:0]          avs_readdata_o,
  input wire logic                 avs_waitrequest_o,
  input wire logic [1:0]           avs_response_o,
  // Field pins and interrupt
  input wire logic [N_INPUTS-1:0]  input_point_i,
  input wire logic                 host_link_ok_i,
  input wire logic [N_OUTPUTS-1:0] output_point_o,
  input wire logic                 irq_o
);
  logic [3:0] up_ff;
  logic       ack;
  logic [3:0] idx;
  assign ack = !avs_waitrequest_o;
  assign idx = avs_address_i[5:2];
  // Cycles the host link has been up, saturating
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) up_ff <= 4'h0;
    else if (!host_link_ok_i) up_ff <= 4'h0;
    else if (up_ff != 4'hf) up_ff <= up_ff + 4'h1;
  end
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  chk_wait_one: assert property (ack |=> avs_waitrequest_o)
    else $error("waitrequest low two cycles");
  chk_wait_answer: assert property
    ($rose(avs_read_i || avs_write_i) |=> ack)
    else $error("no answer one cycle after request");
  chk_resp_ok: assert property
    (ack && idx <= REG_IRQ_CLEAR |-> avs_response_o == 2'h0)
    else $error("mapped access not answered okay");
  chk_resp_err: assert property
    (ack && idx > REG_IRQ_CLEAR |-> avs_response_o == 2'h3)
    else $error("unmapped access not refused");
  chk_in_upper: assert property (
    ack && avs_read_i && idx == REG_INPUT_POINT
    |-> (avs_readdata_o >> N_INPUTS) == 32'h0000_0000)
    else $error("input read has bits above module width");
  chk_out_upper: assert property (
    ack && avs_read_i && idx == REG_OUTPUT_POINT
    |-> (avs_readdata_o >> N_OUTPUTS) == 32'h0000_0000)
    else $error("output read has bits above module width");
  chk_out_write: assert property (
    ack && avs_write_i && idx == REG_OUTPUT_POINT &&
    avs_byteenable_i[0] && up_ff == 4'hf
    |=> output_point_o == $past(avs_writedata_i[N_OUTPUTS-1:0]))
    else $error("output pins differ from written value");
  chk_out_steady: assert property (
    up_ff == 4'hf && avs_waitrequest_o && $past(avs_waitrequest_o)
    |-> $stable(output_point_o))
    else $error("outputs moved with link up and no write");
endmodule

bind discrete_io_fail_safe io_props #(
  .N_INPUTS(N_INPUTS),
  .N_OUTPUTS(N_OUTPUTS)
) io_props_i (.*);

//--- bench/host_link_model.sv
// Remote host that keeps the link alive while it polls
`timescale 1ns/1ns
module host_link_model (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  // Bench control
  input  wire logic stop_poll_i,
  // Link status to the block
  output logic      host_link_ok_o
);
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) host_link_ok_o <= 1'b1;
    else host_link_ok_o <= !stop_poll_i;
  end
endmodule

//--- bench/testbench.sv
// Self-checking bench of the discrete I/O block
`timescale 1ns/1ns
module testbench;
  import dio_pkg::*;
  localparam int TL = 10;
  logic              sys_clk_i        = 1'b0;
  logic              resetn_i         = 1'b0;
  logic [ADDR_W-1:0] avs_address_i    = '0;
  logic              avs_read_i       = 1'b0;
  logic              avs_write_i      = 1'b0;
  logic [3:0]        avs_byteenable_i = 4'hf;
  logic [31:0]       avs_writedata_i  = '0;
  logic [31:0]       avs_readdata_o;
  logic              avs_waitrequest_o;
  logic [1:0]        avs_response_o;
  logic [23:0]       input_point_i    = '0;
  logic              host_link_ok_i;
  logic [3:0]        output_point_o;
  logic              irq_o;
  logic              stop_poll        = 1'b0;
  logic [31:0]       got;
  logic [31:0]       v;
  int                err_count        = 0;
  int                total_checks     = 0;
  int                seed             = 70819;
  always #2 sys_clk_i = ~sys_clk_i;
  discrete_io_fail_safe #(
    .N_INPUTS(24),
    .TICK_LEN(TL)
  ) discrete_io_fail_safe_i (.*);
  host_link_model host_link_model_i (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .stop_poll_i(stop_poll),
    .host_link_ok_o(host_link_ok_i)
  );
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [3:0] idx, logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_i   <= {idx, 2'b00};
    avs_read_i      <= !w;
    avs_write_i     <= w;
    avs_writedata_i <= d;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) err_count++;
    got = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  function automatic logic [3:0] safe_val(int t, logic [3:0] p);
    return (t == 1) ? 4'h0 : (t == 2) ? p : 4'ha;
  endfunction
  task automatic wait_out(logic [3:0] exp, int lim);
    for (int n = 0; n < lim && output_point_o !== exp; n++) begin
      @(negedge sys_clk_i);
    end
    check("outputs", {28'h0, output_point_o}, {28'h0, exp});
    @(posedge sys_clk_i);
  endtask
  task automatic setup(int t, logic [31:0] p, logic [7:0] d);
    bus(1'b1, REG_SAFE_SELECT, 32'(t));
    bus(1'b1, REG_SAFE_PATTERN, p);
    bus(1'b1, REG_SAFE_DELAY, {24'h0, d});
    bus(1'b1, REG_SAFE_COMMIT, 32'h0000_0001);
  endtask
  task automatic early(logic [7:0] d);
    setup(1, 32'h0, d);
    stop_poll <= 1'b1;
    repeat (int'(d) * TL - 5) @(posedge sys_clk_i);
    check("early", {28'h0, output_point_o}, 32'ha);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #(4 * 20000);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (6) begin
      input_point_i <= 24'($random(seed));
      bus(1'b1, REG_INPUT_POINT, 32'hffff_ffff);
      bus(1'b0, REG_INPUT_POINT, 32'h0);
      check("inputs", got, {8'h00, input_point_i});
    end
    $display("input test done");
    repeat (6) begin
      v = $random(seed);
      bus(1'b1, REG_OUTPUT_POINT, v);
      bus(1'b0, REG_OUTPUT_POINT, 32'h0);
      check("out read", got, {28'h0, v[3:0]});
    end
    bus(1'b0, 4'hc, 32'h0);
    check("unmapped", {avs_response_o, got[29:0]}, 32'hc000_0000);
    $display("bus test done");
    // Staged type and pattern with a zero commit stay inert
    bus(1'b1, REG_OUTPUT_POINT, 32'ha);
    bus(1'b1, REG_SAFE_SELECT, 32'h2);
    bus(1'b1, REG_SAFE_PATTERN, 32'h5);
    bus(1'b1, REG_SAFE_COMMIT, 32'h0);
    stop_poll <= 1'b1;
    wait_out(4'h0, 8);
    stop_poll <= 1'b0;
    wait_out(4'ha, 20);
    for (int t = 1; t <= 3; t++) begin
      v = {28'($random(seed)), 4'h5};
      setup(t, v, 8'h00);
      stop_poll <= 1'b1;
      wait_out(safe_val(t, v[3:0]), 8);
      stop_poll <= 1'b0;
      wait_out(4'ha, 20);
    end
    $display("type test done");
    early(8'h03);
    stop_poll <= 1'b0;
    v = 32'ha;
    repeat (4 * TL) begin
      @(posedge sys_clk_i);
      if (output_point_o !== 4'ha) v = {28'h0, output_point_o};
    end
    check("cancel", v, 32'ha);
    early(8'hff);
    bus(1'b0, REG_STATUS, 32'h0);
    check("pending", got, 32'(1) << STAT_PEND_BIT);
    wait_out(4'h0, 20);
    stop_poll <= 1'b0;
    wait_out(4'ha, 20);
    $display("delay test done");
    bus(1'b1, REG_IRQ_CLEAR, 32'h7);
    bus(1'b1, REG_IRQ_ENABLE, 32'h1);
    stop_poll <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    check("irq set", {31'h0, irq_o}, 32'h1);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    check("irq status", got & 32'h1, 32'h1);
    bus(1'b1, REG_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    check("irq mask", {31'h0, irq_o}, 32'h0);
    bus(1'b1, REG_IRQ_CLEAR, 32'h1);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    check("irq clear", got & 32'h1, 32'h0);
    stop_poll <= 1'b0;
    $display("irq test done");
    wrap_up();
  end
endmodule
